// ==== icsm_irq_ctrl.sv ====
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

module icsm_irq_ctrl #(
  parameter int SUPPLY_IRQ_CYC = icsm_pkg::SUPPLY_IRQ_CYC
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  // Register port
  input wire logic [icsm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [icsm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [icsm_pkg::DATA_W-1:0] reg_rdata,
  // Asynchronous inputs
  input wire logic ext_irq_pin,
  input wire logic lvd_comp_out,
  // Request pulses from on-chip sources
  input wire logic timer_p_period_evt,
  input wire logic timer_p_match_a_evt,
  input wire logic timer_s_period_evt,
  input wire logic timer_s_match_a_evt,
  input wire logic timebase0_evt,
  input wire logic timebase1_evt,
  input wire logic eeprom_evt,
  input wire logic converter_evt,
  input wire logic serial_if_evt,
  // Core and power state
  input wire logic irq_ack,
  input wire logic sleep_mode,
  input wire logic brownout_reset_en,
  // Outputs to core and analog
  output logic irq_pending,
  output logic wake_req,
  output logic global_irq_enable,
  output logic detector_on,
  output logic bandgap_on,
  output logic [icsm_pkg::THR_W-1:0] threshold_sel,
  output logic low_voltage_flag
);

  localparam int CNT_W = $clog2(SUPPLY_IRQ_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SUPPLY_IRQ_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(SUPPLY_IRQ_CYC);

  // Next register value: write under mask, then hardware sets on top
  function automatic logic [7:0] reg_update(
    input logic [7:0] cur,
    input logic [7:0] wdata,
    input logic [7:0] wmask,
    input logic we,
    input logic [7:0] set
  );
    logic [7:0] base;
    base = we ? ((cur & ~wmask) | (wdata & wmask)) : cur;
    reg_update = base | set;
  endfunction

  // Register storage, indexed
  logic [7:0] regs [icsm_pkg::NUM_REGS];
  logic [7:0] next_regs [icsm_pkg::NUM_REGS];

  // Synchroniser stages and filtered levels
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;
  logic ext_q;
  logic ext_prev;
  logic cmp_s1;
  logic cmp_s2;
  logic cmp_s3;
  logic cmp_q;

  // Supply-low delay counter
  logic [CNT_W-1:0] low_cnt;
  logic [CNT_W-1:0] next_low_cnt;

  // Field decode
  wire logic [7:0] mon_reg = regs[icsm_pkg::IDX_SUPPLY_MON];
  wire logic [7:0] edge_reg = regs[icsm_pkg::IDX_EDGE_CFG];
  wire logic [7:0] ctl0 = regs[icsm_pkg::IDX_IRQ_CTL0];
  wire logic [7:0] ctl1 = regs[icsm_pkg::IDX_IRQ_CTL1];
  wire logic [7:0] ctl2 = regs[icsm_pkg::IDX_IRQ_CTL2];
  wire logic [7:0] ctl3 = regs[icsm_pkg::IDX_IRQ_CTL3];
  wire logic det_en = mon_reg[icsm_pkg::DET_EN_BIT];
  wire logic bg_buf_en = mon_reg[icsm_pkg::BG_BUF_BIT];
  wire logic [1:0] edge_sel = edge_reg[icsm_pkg::EDGE_LSB +: 2];
  wire logic gie = ctl0[icsm_pkg::GIE_BIT];

  // Detector power and bandgap request
  wire logic det_active = det_en & ~sleep_mode;
  wire logic next_bandgap = det_en | brownout_reset_en | bg_buf_en;

  // Edge detection on the filtered pin level
  wire logic ext_rise = ext_q & ~ext_prev;
  wire logic ext_fall = ~ext_q & ext_prev;
  logic ext_evt;

  always_comb
  begin
    case (icsm_pkg::icsm_edge_t'(edge_sel))
      icsm_pkg::EDGE_OFF: ext_evt = 1'b0;
      icsm_pkg::EDGE_RISE: ext_evt = ext_rise;
      icsm_pkg::EDGE_FALL: ext_evt = ext_fall;
      icsm_pkg::EDGE_BOTH: ext_evt = ext_rise | ext_fall;
      default: ext_evt = 1'b0;
    endcase
  end

  // Supply-low event fires once when the flag has held for the full delay
  wire logic supply_evt = low_voltage_flag && (low_cnt == CNT_LAST);

  // Counter restarts on every drop, so chatter near threshold never fires early
  always_comb
  begin
    if (!low_voltage_flag)
    begin
      next_low_cnt = '0;
    end
    else if (low_cnt != CNT_FULL)
    begin
      next_low_cnt = low_cnt + CNT_W'(1);
    end
    else
    begin
      next_low_cnt = low_cnt;
    end
  end

  // Hardware set vectors per register
  wire logic [7:0] set_ctl0 = {1'b0, ext_evt, 6'h00};
  wire logic [7:0] set_ctl1 = {eeprom_evt, converter_evt, supply_evt, serial_if_evt,
                               4'h0};
  wire logic [7:0] set_ctl2 = {timer_s_match_a_evt, timer_s_period_evt,
                               timer_p_match_a_evt, timer_p_period_evt, 4'h0};
  wire logic [7:0] set_ctl3 = {2'b00, timebase1_evt, timebase0_evt, 4'h0};

  // Write decode
  wire logic wr_mon = reg_wr && (reg_addr == icsm_pkg::IDX_SUPPLY_MON);
  wire logic wr_edge = reg_wr && (reg_addr == icsm_pkg::IDX_EDGE_CFG);
  wire logic wr_ctl0 = reg_wr && (reg_addr == icsm_pkg::IDX_IRQ_CTL0);
  wire logic wr_ctl1 = reg_wr && (reg_addr == icsm_pkg::IDX_IRQ_CTL1);
  wire logic wr_ctl2 = reg_wr && (reg_addr == icsm_pkg::IDX_IRQ_CTL2);
  wire logic wr_ctl3 = reg_wr && (reg_addr == icsm_pkg::IDX_IRQ_CTL3);

  // Control 0 after write and set; service entry then drops global enable
  wire logic [7:0] ctl0_upd = reg_update(ctl0, reg_wdata, icsm_pkg::WMASK_IRQ_CTL0,
                                         wr_ctl0, set_ctl0);
  wire logic [7:0] gie_clr = irq_ack ? (8'h01 << icsm_pkg::GIE_BIT) : 8'h00;

  // Next values of every register; set terms are ORed last so events win
  always_comb
  begin
    next_regs[icsm_pkg::IDX_SUPPLY_MON] = reg_update(mon_reg, reg_wdata,
      icsm_pkg::WMASK_SUPPLY_MON, wr_mon, 8'h00);
    next_regs[icsm_pkg::IDX_EDGE_CFG] = reg_update(edge_reg, reg_wdata,
      icsm_pkg::WMASK_EDGE_CFG, wr_edge, 8'h00);
    next_regs[icsm_pkg::IDX_IRQ_CTL0] = ctl0_upd & ~gie_clr;
    next_regs[icsm_pkg::IDX_IRQ_CTL1] = reg_update(ctl1, reg_wdata,
      icsm_pkg::WMASK_IRQ_CTL1, wr_ctl1, set_ctl1);
    next_regs[icsm_pkg::IDX_IRQ_CTL2] = reg_update(ctl2, reg_wdata,
      icsm_pkg::WMASK_IRQ_CTL2, wr_ctl2, set_ctl2);
    next_regs[icsm_pkg::IDX_IRQ_CTL3] = reg_update(ctl3, reg_wdata,
      icsm_pkg::WMASK_IRQ_CTL3, wr_ctl3, set_ctl3);
  end

  // Flag and enable pairing for the request output
  wire logic [7:0] flags_all = {ctl0[icsm_pkg::EXT_FLAG_BIT],
                                ctl1[icsm_pkg::FLAG_LSB +: 4],
                                ctl3[icsm_pkg::FLAG_LSB +: 2], 1'b0};
  wire logic [7:0] enables_all = {ctl0[icsm_pkg::EXT_EN_BIT],
                                  ctl1[icsm_pkg::EN_LSB +: 4],
                                  ctl3[icsm_pkg::EN_LSB +: 2], 1'b0};
  wire logic [3:0] tmr_pend = ctl2[icsm_pkg::FLAG_LSB +: 4] & ctl2[icsm_pkg::EN_LSB +: 4];
  wire logic any_enabled = (|(flags_all & enables_all)) | (|tmr_pend);
  wire logic next_irq = gie & any_enabled;
  // Any set flag wakes the core, enabled or not
  wire logic next_wake = (|flags_all) | (|ctl2[icsm_pkg::FLAG_LSB +: 4]);

  // Read mux; unimplemented bits and unmapped indices give zero
  logic [7:0] rd_value;

  always_comb
  begin
    case (reg_addr)
      icsm_pkg::IDX_SUPPLY_MON:
        rd_value = (mon_reg & icsm_pkg::WMASK_SUPPLY_MON)
                 | ({7'h00, low_voltage_flag} << icsm_pkg::LVD_FLAG_BIT);
      icsm_pkg::IDX_EDGE_CFG: rd_value = edge_reg & icsm_pkg::WMASK_EDGE_CFG;
      icsm_pkg::IDX_IRQ_CTL0: rd_value = ctl0 & icsm_pkg::WMASK_IRQ_CTL0;
      icsm_pkg::IDX_IRQ_CTL1: rd_value = ctl1;
      icsm_pkg::IDX_IRQ_CTL2: rd_value = ctl2;
      icsm_pkg::IDX_IRQ_CTL3: rd_value = ctl3 & icsm_pkg::WMASK_IRQ_CTL3;
      default: rd_value = 8'h00;
    endcase
  end

  // Pin synchroniser; third stage filters single-cycle disagreement
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      ext_q <= 1'b0;
      ext_prev <= 1'b0;
    end
    else if (clk_en)
    begin
      ext_s1 <= ext_irq_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      if (ext_s2 == ext_s3)
      begin
        ext_q <= ext_s3;
      end
      ext_prev <= ext_q;
    end
  end

  // Comparator synchroniser, same scheme as the pin
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_s3 <= 1'b0;
      cmp_q <= 1'b0;
    end
    else if (clk_en)
    begin
      cmp_s1 <= lvd_comp_out;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      if (cmp_s2 == cmp_s3)
      begin
        cmp_q <= cmp_s3;
      end
    end
  end

  // Low-voltage flag and its hold counter
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      low_voltage_flag <= 1'b0;
      low_cnt <= '0;
    end
    else if (clk_en)
    begin
      low_voltage_flag <= det_active & cmp_q;
      low_cnt <= next_low_cnt;
    end
  end

  // Register file
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      for (int i = 0; i < icsm_pkg::NUM_REGS; i++)
      begin
        regs[i] <= icsm_pkg::REG_RESET;
      end
    end
    else if (clk_en)
    begin
      for (int i = 0; i < icsm_pkg::NUM_REGS; i++)
      begin
        regs[i] <= next_regs[i];
      end
    end
  end

  // Registered outputs; read data stands one cycle only
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      reg_rdata <= 8'h00;
      irq_pending <= 1'b0;
      wake_req <= 1'b0;
      global_irq_enable <= 1'b0;
      detector_on <= 1'b0;
      bandgap_on <= 1'b0;
      threshold_sel <= '0;
    end
    else if (clk_en)
    begin
      reg_rdata <= reg_rd ? rd_value : 8'h00;
      irq_pending <= next_irq;
      wake_req <= next_wake;
      global_irq_enable <= gie;
      detector_on <= det_active;
      bandgap_on <= next_bandgap;
      threshold_sel <= mon_reg[icsm_pkg::THR_LSB +: icsm_pkg::THR_W];
    end
  end

endmodule

// ==== icsm_irq_ctrl_props.sv ====
`timescale 1ns/1ps
module icsm_irq_ctrl_props #(
  parameter int SUPPLY_IRQ_CYC = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Core, power and one source
  input wire logic eeprom_evt,
  input wire logic irq_ack,
  input wire logic sleep_mode,
  input wire logic brownout_reset_en,
  // Derived outputs
  input wire logic irq_pending,
  input wire logic wake_req,
  input wire logic global_irq_enable,
  input wire logic detector_on,
  input wire logic bandgap_on,
  input wire logic [2:0] threshold_sel,
  input wire logic low_voltage_flag
);
  // One clock domain; reset masks every check
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  // Read data only in the cycle after a read
  property p_rd0;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside slot");
  property p_unm;
    $past(reg_rd) && $past(reg_addr) > 3'h5 |-> reg_rdata == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_top;
    $past(reg_rd) && $past(reg_addr) == icsm_pkg::IDX_SUPPLY_MON |-> reg_rdata[7:6] == 2'b00;
  endproperty
  a_top: assert property (p_top) else $error("monitor top bits set");
  property p_thr;
    reg_wr && reg_addr == icsm_pkg::IDX_SUPPLY_MON |-> ##2 threshold_sel == $past(reg_wdata[2:0], 2);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold not taken");
  property p_gie;
    reg_wr && reg_addr == icsm_pkg::IDX_IRQ_CTL0 && !irq_ack
      |-> ##2 global_irq_enable == $past(reg_wdata[0], 2);
  endproperty
  a_gie: assert property (p_gie) else $error("global enable not taken");
  property p_ack;
    irq_ack |-> ##2 !global_irq_enable;
  endproperty
  a_ack: assert property (p_ack) else $error("ack left enable set");
  property p_mask;
    !global_irq_enable |-> !irq_pending;
  endproperty
  a_mask: assert property (p_mask) else $error("pending while disabled");
  property p_wake;
    eeprom_evt |-> ##2 wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake after event");
  property p_slp;
    sleep_mode |=> !detector_on;
  endproperty
  a_slp: assert property (p_slp) else $error("detector on in sleep");
  property p_slf;
    sleep_mode [*2] |=> !low_voltage_flag;
  endproperty
  a_slf: assert property (p_slf) else $error("low flag in sleep");
  property p_bg;
    brownout_reset_en |=> bandgap_on;
  endproperty
  a_bg: assert property (p_bg) else $error("bandgap off with brownout");
endmodule

// ==== icsm_pkg.sv ====
package icsm_pkg;

  // Register port geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 6;

  // Register indices on the plain register port
  localparam logic [2:0] IDX_SUPPLY_MON = 3'h0;
  localparam logic [2:0] IDX_EDGE_CFG = 3'h1;
  localparam logic [2:0] IDX_IRQ_CTL0 = 3'h2;
  localparam logic [2:0] IDX_IRQ_CTL1 = 3'h3;
  localparam logic [2:0] IDX_IRQ_CTL2 = 3'h4;
  localparam logic [2:0] IDX_IRQ_CTL3 = 3'h5;

  // Value of every register after reset
  localparam logic [7:0] REG_RESET = 8'h00;

  // Writable bits; anything outside reads as zero, except the supply monitor's low-voltage flag bit
  localparam logic [7:0] WMASK_SUPPLY_MON = 8'h1F;
  localparam logic [7:0] WMASK_EDGE_CFG = 8'h0F;
  localparam logic [7:0] WMASK_IRQ_CTL0 = 8'h7F;
  localparam logic [7:0] WMASK_IRQ_CTL1 = 8'hFF;
  localparam logic [7:0] WMASK_IRQ_CTL2 = 8'hFF;
  localparam logic [7:0] WMASK_IRQ_CTL3 = 8'h77;

  // Supply monitor control fields
  localparam int LVD_FLAG_BIT = 5;
  localparam int DET_EN_BIT = 4;
  localparam int BG_BUF_BIT = 3;
  localparam int THR_LSB = 0;
  localparam int THR_W = 3;

  // Threshold in millivolts for each code of threshold_select
  localparam int THRESHOLD_MV [8] = '{2000, 2200, 2400, 2700, 3000, 3300, 3600, 4000};

  // Edge configuration field
  localparam int EDGE_LSB = 2;

  // Interrupt control 0 fields
  localparam int EXT_FLAG_BIT = 6;
  localparam int EXT_EN_BIT = 3;
  localparam int GIE_BIT = 0;

  // Flag nibble of control registers 1 and 2, enables in the low nibble
  localparam int FLAG_LSB = 4;
  localparam int EN_LSB = 0;

  // Timing at the 50 MHz system clock
  localparam int CLK_PERIOD_NS = 20;
  localparam int SUPPLY_IRQ_DELAY_NS = 100000;
  localparam int SUPPLY_IRQ_CYC = (SUPPLY_IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // External pin edge selection
  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } icsm_edge_t;

endpackage

// ==== icsm_src_model.sv ====
`timescale 1ns/1ps
module icsm_src_model (
  // Clock
  input wire logic mclk,
  // Request lines toward the controller
  output logic [8:0] evt,
  output logic pin,
  output logic comp
);
  // Idle: no requests, pin low, supply healthy
  initial
  begin
    evt = '0;
    pin = 1'b0;
    comp = 1'b0;
  end
  // One-cycle pulse, same clock as the controller
  task automatic pulse(input logic [8:0] m);
    @(posedge mclk);
    evt <= m;
    @(posedge mclk);
    evt <= '0;
  endtask
  // Pin and comparator are asynchronous, so move them mid-cycle
  task automatic set_lvl(input logic p, input logic c);
    @(negedge mclk);
    #3;
    pin = p;
    comp = c;
  endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  // Stimulus, outputs and bookkeeping
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic [2:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic irq_ack = 1'b0;
  logic sleep_mode = 1'b0;
  logic brownout_reset_en = 1'b0;
  logic [7:0] reg_rdata;
  logic irq_pending, wake_req, global_irq_enable, detector_on, bandgap_on, low_voltage_flag;
  logic [2:0] threshold_sel;
  logic [8:0] evt;
  logic pin, comp;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q [$];
  logic [7:0] acc [8];
  logic [7:0] d;
  int n_fail = 0;
  int num_checks = 0;
  int k;
  // Source order: timer p period, p match, s period, s match, tb0, tb1, eeprom, adc, serial
  localparam logic [2:0] SREG [9] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h5, 3'h5, 3'h3, 3'h3, 3'h3};
  localparam logic [7:0] SBIT [9] = '{8'h10, 8'h20, 8'h40, 8'h80, 8'h10, 8'h20, 8'h80, 8'h40, 8'h10};
  localparam logic [7:0] WM [8] = '{icsm_pkg::WMASK_SUPPLY_MON, icsm_pkg::WMASK_EDGE_CFG,
    icsm_pkg::WMASK_IRQ_CTL0, icsm_pkg::WMASK_IRQ_CTL1, icsm_pkg::WMASK_IRQ_CTL2,
    icsm_pkg::WMASK_IRQ_CTL3, 8'h00, 8'h00};

  always #10 mclk = ~mclk;

  icsm_src_model src (.mclk(mclk), .evt(evt), .pin(pin), .comp(comp));

  icsm_irq_ctrl #(.SUPPLY_IRQ_CYC(4)) uut (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_pin(pin),
    .lvd_comp_out(comp), .timer_p_period_evt(evt[0]), .timer_p_match_a_evt(evt[1]),
    .timer_s_period_evt(evt[2]), .timer_s_match_a_evt(evt[3]), .timebase0_evt(evt[4]),
    .timebase1_evt(evt[5]), .eeprom_evt(evt[6]), .converter_evt(evt[7]),
    .serial_if_evt(evt[8]), .irq_ack(irq_ack), .sleep_mode(sleep_mode),
    .brownout_reset_en(brownout_reset_en), .irq_pending(irq_pending), .wake_req(wake_req),
    .global_irq_enable(global_irq_enable), .detector_on(detector_on),
    .bandgap_on(bandgap_on), .threshold_sel(threshold_sel),
    .low_voltage_flag(low_voltage_flag));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read notes its expectation; the watcher compares
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask

  // Wait, then sample after the edge's updates land
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk)
  begin
    if (rd_seen)
      check(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
  end

  initial
  begin
    void'($urandom(32'h8801));
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    for (int a = 0; a < 8; a++)
      rd(3'(a), 8'h00);
    for (int a = 0; a < 8; a++)
    begin
      d = 8'($urandom);
      wr(3'(a), d);
      rd(3'(a), d & WM[a]);
    end
    for (int c = 0; c < 8; c++)
    begin
      wr(icsm_pkg::IDX_SUPPLY_MON, 8'(c));
      rd(icsm_pkg::IDX_SUPPLY_MON, 8'(c));
    end
    for (int a = 0; a < 8; a++)
    begin
      wr(3'(a), 8'h00);
      acc[a] = 8'h00;
    end
    // Every source, enables all off: flags still set
    for (int i = 0; i < 9; i++)
    begin
      src.pulse(9'(1 << i));
      acc[SREG[i]] |= SBIT[i];
      rd(SREG[i], acc[SREG[i]]);
    end
    settle(2);
    check({7'h00, irq_pending}, 8'h00);
    check({7'h00, wake_req}, 8'h01);
    wr(icsm_pkg::IDX_IRQ_CTL1, acc[3] | 8'h01);
    wr(icsm_pkg::IDX_IRQ_CTL0, 8'h01);
    settle(2);
    check({7'h00, irq_pending}, 8'h01);
    @(posedge mclk);
    irq_ack <= 1'b1;
    @(posedge mclk);
    irq_ack <= 1'b0;
    settle(2);
    check({7'h00, irq_pending}, 8'h00);
    rd(icsm_pkg::IDX_IRQ_CTL1, acc[3] | 8'h01);
    // Clearing write meets an event on the same edge
    fork
      wr(icsm_pkg::IDX_IRQ_CTL1, 8'h00);
      src.pulse(9'h040);
    join
    rd(icsm_pkg::IDX_IRQ_CTL1, 8'h80);
    // Each edge mode against a rising then a falling pin
    for (int m = 0; m < 4; m++)
    begin
      wr(icsm_pkg::IDX_EDGE_CFG, 8'(m << 2));
      wr(icsm_pkg::IDX_IRQ_CTL0, 8'h00);
      src.set_lvl(1'b1, 1'b0);
      settle(10);
      rd(icsm_pkg::IDX_IRQ_CTL0, {1'b0, m[0], 6'h00});
      wr(icsm_pkg::IDX_IRQ_CTL0, 8'h00);
      src.set_lvl(1'b0, 1'b0);
      settle(10);
      rd(icsm_pkg::IDX_IRQ_CTL0, {1'b0, m[1], 6'h00});
    end
    // Supply low: flag at once, request only after the delay
    wr(icsm_pkg::IDX_IRQ_CTL1, 8'h00);
    wr(icsm_pkg::IDX_SUPPLY_MON, 8'h10);
    settle(4);
    check({7'h00, bandgap_on}, 8'h01);
    src.set_lvl(1'b0, 1'b1);
    for (k = 0; k < 50 && low_voltage_flag !== 1'b1; k++)
      @(negedge mclk);
    if (k == 50)
    begin
      n_fail++;
      end_sim();
    end
    rd(icsm_pkg::IDX_IRQ_CTL1, 8'h00);
    rd(icsm_pkg::IDX_SUPPLY_MON, 8'h30);
    settle(8);
    rd(icsm_pkg::IDX_IRQ_CTL1, 8'h20);
    @(posedge mclk);
    sleep_mode <= 1'b1;
    settle(4);
    check({7'h00, detector_on}, 8'h00);
    rd(icsm_pkg::IDX_SUPPLY_MON, 8'h10);
    sleep_mode <= 1'b0;
    src.set_lvl(1'b0, 1'b0);
    wr(icsm_pkg::IDX_SUPPLY_MON, 8'h00);
    settle(3);
    check({7'h00, bandgap_on}, 8'h00);
    brownout_reset_en <= 1'b1;
    settle(3);
    check({7'h00, bandgap_on}, 8'h01);
    brownout_reset_en <= 1'b0;
    wr(icsm_pkg::IDX_SUPPLY_MON, 8'h08);
    settle(3);
    check({7'h00, bandgap_on}, 8'h01);
    settle(4);
    end_sim();
  end
endmodule

bind icsm_irq_ctrl icsm_irq_ctrl_props #(.SUPPLY_IRQ_CYC(SUPPLY_IRQ_CYC)) u_props (.*);
